// file: smled_encoder.v
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "smled_defines.vh"

module smled_encoder #(
   parameter SLOT_CYC = `SMLED_SLOT_CYC,
   parameter NCH      = 2
) (
   // clock and reset
   input  wire           clk_i,
   input  wire           arst_n_i,
   // module condition
   input  wire           mod_supply_i,
   input  wire           io_supply_i,
   input  wire [2:0]     mod_state_i,
   input  wire           startup_i,
   input  wire           link_ok_i,
   input  wire           cpu_ok_i,
   input  wire           safe_comm_ok_i,
   input  wire           fw_pilot_i,
   input  wire           fw_inoperable_i,
   input  wire           safety_active_i,
   // channel condition
   input  wire [NCH-1:0] ch_err_i,
   input  wire [NCH-1:0] ch_nonsafe_i,
   input  wire [NCH-1:0] ch_set_i,
   // avalon-mm slave
   input  wire [3:0]     avs_address_i,
   input  wire           avs_read_i,
   input  wire           avs_write_i,
   input  wire [31:0]    avs_writedata_i,
   output reg  [31:0]    avs_readdata_o,
   output wire           avs_waitrequest_o,
   // lamps
   output reg            run_green_o,
   output reg            err_red_o,
   output reg  [NCH-1:0] ch_red_o,
   output reg  [NCH-1:0] ch_orange_o,
   output reg            safety_state_indicator_o,
   // diagnostics
   output reg            inop_diag_o,
   output wire           irq_o
);

   reg [31:0] slot_cnt_r;
   reg [3:0]  frame_r;
   wire       slot_tick;

   // single time base: 12 slots per frame, every pattern reads this phase
   assign slot_tick = (slot_cnt_r == SLOT_CYC - 1);

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         slot_cnt_r <= 32'h0000_0000;
         frame_r    <= 4'h0;
      end else if (slot_tick) begin
         slot_cnt_r <= 32'h0000_0000;
         frame_r    <= (frame_r == `SMLED_FRAME_SLOTS - 4'h1) ? 4'h0 : frame_r + 4'h1;
      end else begin
         slot_cnt_r <= slot_cnt_r + 32'h0000_0001;
      end
   end

   // n flashes: on in slots 0,2,..,2n-2 then dark to end of frame
   function burst;
      input [3:0] ph;
      input [3:0] n;
      begin
         burst = (ph < {n[2:0], 1'b0}) && !ph[0];
      end
   endfunction

   // pattern codes shared by the run and error lamps
   localparam P_OFF    = 3'h0;
   localparam P_ON     = 3'h1;
   localparam P_FLASH  = 3'h2;
   localparam P_SINGLE = 3'h3;
   localparam P_DOUBLE = 3'h4;
   localparam P_TRIPLE = 3'h5;

   function pat;
      input [2:0] sel;
      input [3:0] ph;
      begin
         case (sel)
            P_ON: begin
               pat = 1'b1;
            end
            P_FLASH: begin
               pat = !ph[0];
            end
            P_SINGLE: begin
               pat = burst(ph, 4'h1);
            end
            P_DOUBLE: begin
               pat = burst(ph, 4'h2);
            end
            P_TRIPLE: begin
               pat = burst(ph, 4'h3);
            end
            default: begin
               pat = 1'b0;
            end
         endcase
      end
   endfunction

   // one-hot view of the module state
   localparam S_RESET  = 7'h01;
   localparam S_BOOT   = 7'h02;
   localparam S_FWUPD  = 7'h04;
   localparam S_PREOP  = 7'h08;
   localparam S_RUN    = 7'h10;
   localparam S_ERROR  = 7'h20;
   localparam S_BADCFG = 7'h40;

   // the unused code 7 falls to error so a corrupt state never looks healthy
   function [6:0] st_dec;
      input [2:0] code;
      begin
         case (code)
            `SMLED_ST_RESET: begin
               st_dec = S_RESET;
            end
            `SMLED_ST_BOOT: begin
               st_dec = S_BOOT;
            end
            `SMLED_ST_FWUPD: begin
               st_dec = S_FWUPD;
            end
            `SMLED_ST_PREOP: begin
               st_dec = S_PREOP;
            end
            `SMLED_ST_RUN: begin
               st_dec = S_RUN;
            end
            `SMLED_ST_BADCFG: begin
               st_dec = S_BADCFG;
            end
            default: begin
               st_dec = S_ERROR;
            end
         endcase
      end
   endfunction

   wire [6:0] st_oh = st_dec(mod_state_i);

   // control / interrupt registers
   reg                        force_lamp_r;
   reg [`SMLED_IRQ_WIDTH-1:0] irq_stat_r;
   reg [`SMLED_IRQ_WIDTH-1:0] irq_en_r;
   reg [`SMLED_IRQ_WIDTH-1:0] ev_prev_r;
   reg                        rd_pend_r;
   wire                       inop;
   wire [`SMLED_IRQ_WIDTH-1:0] ev_now;

   // inoperative: any condition, other than the lamp test, that lights the safety-state lamp
   assign inop = io_supply_i && st_oh != S_RUN &&
                 (st_oh == S_BOOT || !link_ok_i || !cpu_ok_i ||
                  st_oh == S_PREOP || !safe_comm_ok_i ||
                  fw_pilot_i || fw_inoperable_i || safety_active_i);
   assign ev_now = {ch_err_i[1], ch_err_i[0], inop};

   // reads take one wait cycle so readdata is registered
   assign avs_waitrequest_o = avs_read_i && !rd_pend_r;
   assign irq_o = |(irq_stat_r & irq_en_r);

   wire wr_clr = avs_write_i && avs_address_i == `SMLED_OFF_IRQ_STAT;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         force_lamp_r   <= 1'b0;
         irq_stat_r     <= 3'h0;
         irq_en_r       <= 3'h0;
         ev_prev_r      <= 3'h0;
         rd_pend_r      <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         ev_prev_r <= ev_now;
         rd_pend_r <= avs_read_i && !rd_pend_r;
         if (avs_write_i && avs_address_i == `SMLED_OFF_CTRL) begin
            force_lamp_r <= avs_writedata_i[`SMLED_CTRL_FORCE_LAMP];
         end
         if (avs_write_i && avs_address_i == `SMLED_OFF_IRQ_EN) begin
            irq_en_r <= avs_writedata_i[`SMLED_IRQ_WIDTH-1:0];
         end
         // rising edge sets; set beats a same-cycle clear
         irq_stat_r <= (irq_stat_r & ~(wr_clr ? avs_writedata_i[2:0] : 3'h0)) |
                       (ev_now & ~ev_prev_r);
         if (avs_read_i && !rd_pend_r) begin
            case (avs_address_i)
               `SMLED_OFF_CTRL: begin
                  avs_readdata_o <= {31'h0, force_lamp_r};
               end
               `SMLED_OFF_STATUS: begin
                  avs_readdata_o <= {24'h0, ch_orange_o, ch_red_o, err_red_o, run_green_o,
                                     safety_state_indicator_o, inop_diag_o};
               end
               `SMLED_OFF_IRQ_STAT: begin
                  avs_readdata_o <= {29'h0, irq_stat_r};
               end
               `SMLED_OFF_IRQ_EN: begin
                  avs_readdata_o <= {29'h0, irq_en_r};
               end
               default: begin
                  avs_readdata_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // lamp encoding
   reg           run_nxt;
   reg           err_nxt;
   reg [NCH-1:0] red_nxt;
   reg [NCH-1:0] org_nxt;
   reg           sse_nxt;
   integer       k;

   always @* begin
      run_nxt = 1'b0;
      err_nxt = 1'b0;
      red_nxt = {NCH{1'b0}};
      org_nxt = {NCH{1'b0}};
      sse_nxt = 1'b0;
      if (mod_supply_i) begin
         case (st_oh)
            S_RESET: begin
               run_nxt = pat(P_SINGLE, frame_r);
            end
            S_BOOT: begin
               err_nxt = pat(P_FLASH, frame_r);
            end
            S_FWUPD: begin
               run_nxt = pat(P_DOUBLE, frame_r);
               err_nxt = pat(P_TRIPLE, frame_r);
            end
            S_PREOP: begin
               run_nxt = pat(P_FLASH, frame_r);
            end
            S_RUN: begin
               run_nxt = pat(P_ON, frame_r);
            end
            S_BADCFG: begin
               err_nxt = pat(P_ON, frame_r);
               run_nxt = pat(P_SINGLE, frame_r);
            end
            default: begin
               err_nxt = pat(P_ON, frame_r);
               run_nxt = pat(P_OFF, frame_r);
            end
         endcase
         for (k = 0; k < NCH; k = k + 1) begin
            if (startup_i || ch_err_i[k] || ch_nonsafe_i[k]) begin
               red_nxt[k] = 1'b1;
            end else begin
               org_nxt[k] = ch_set_i[k];
            end
         end
      end
      sse_nxt = inop;
      // lamp test lights every lamp except the channel orange lamps so a dead lamp is visible
      if (force_lamp_r) begin
         run_nxt = 1'b1;
         err_nxt = 1'b1;
         red_nxt = {NCH{1'b1}};
         sse_nxt = 1'b1;
      end
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         run_green_o              <= 1'b0;
         err_red_o                <= 1'b0;
         ch_red_o                 <= {NCH{1'b0}};
         ch_orange_o              <= {NCH{1'b0}};
         safety_state_indicator_o <= 1'b0;
         inop_diag_o              <= 1'b0;
      end else begin
         run_green_o              <= run_nxt;
         err_red_o                <= err_nxt;
         ch_red_o                 <= red_nxt;
         ch_orange_o              <= org_nxt;
         safety_state_indicator_o <= sse_nxt;
         inop_diag_o              <= inop;
      end
   end

endmodule

// file: smled_defines.vh
`ifndef SMLED_DEFINES_VH
`define SMLED_DEFINES_VH

// register byte offsets
`define SMLED_OFF_CTRL      4'h0
`define SMLED_OFF_STATUS    4'h4
`define SMLED_OFF_IRQ_STAT  4'h8
`define SMLED_OFF_IRQ_EN    4'hc

// control register fields
`define SMLED_CTRL_FORCE_LAMP 0
`define SMLED_CTRL_RESET      32'h0000_0000

// interrupt bit positions
`define SMLED_IRQ_INOP    0
`define SMLED_IRQ_CHERR0  1
`define SMLED_IRQ_CHERR1  2
`define SMLED_IRQ_WIDTH   3

// module state encodings
`define SMLED_ST_RESET   3'h0
`define SMLED_ST_BOOT    3'h1
`define SMLED_ST_FWUPD   3'h2
`define SMLED_ST_PREOP   3'h3
`define SMLED_ST_RUN     3'h4
`define SMLED_ST_ERROR   3'h5
`define SMLED_ST_BADCFG  3'h6

// flash timing
`define SMLED_CLK_HZ     10000000
`define SMLED_SLOT_MS    200
`define SMLED_SLOT_CYC   ((`SMLED_CLK_HZ / 1000) * `SMLED_SLOT_MS)
`define SMLED_FRAME_SLOTS 4'hc

`endif

// file: smled_panel.sv
`timescale 1ns/1ps
module smled_panel (
   // lamp drive
   input  wire       red_i,
   input  wire       orange_i,
   // colour the operator sees
   output wire [1:0] col_o
);
   // the red die swamps orange, so red shows when both are driven
   assign col_o = red_i ? 2'h2 : {1'b0, orange_i};
endmodule

// file: smled_encoder_chk.sv
`timescale 1ns/1ps
`include "smled_defines.vh"
module smled_encoder_chk #(parameter NCH = 2) (
   // conditions
   input wire           clk_i,
   input wire           arst_n_i,
   input wire           mod_supply_i,
   input wire           io_supply_i,
   input wire [2:0]     mod_state_i,
   input wire           startup_i,
   input wire           link_ok_i,
   input wire           cpu_ok_i,
   input wire           safe_comm_ok_i,
   input wire           fw_pilot_i,
   input wire           fw_inoperable_i,
   input wire           safety_active_i,
   input wire [NCH-1:0] ch_err_i,
   // lamps
   input wire [NCH-1:0] ch_red_o,
   input wire [NCH-1:0] ch_orange_o,
   input wire           safety_state_indicator_o,
   input wire           inop_diag_o
);
   // lamp test is only used outside the run state, so the dark check stays valid
   wire ss = safety_state_indicator_o;
   wire sa = io_supply_i && mod_state_i != `SMLED_ST_RUN;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_sd; mod_state_i == `SMLED_ST_RUN || !io_supply_i |-> ##1 !ss; endproperty
   a_sd: assert property (p_sd) else $error("safety lamp lit");
   property p_sb; sa && (!link_ok_i || !cpu_ok_i || mod_state_i == `SMLED_ST_BOOT)
      |=> ss; endproperty
   a_sb: assert property (p_sb) else $error("safety lamp dark in boot");
   property p_sp; sa && (!safe_comm_ok_i || mod_state_i == `SMLED_ST_PREOP) |=> ss; endproperty
   a_sp: assert property (p_sp) else $error("safety lamp dark in preop");
   property p_sf; sa && (fw_pilot_i || fw_inoperable_i) |=> ss; endproperty
   a_sf: assert property (p_sf) else $error("safety lamp dark on firmware");
   property p_si; sa && safety_active_i |=> ss && inop_diag_o; endproperty
   a_si: assert property (p_si) else $error("inoperative not shown");
   property p_cs; mod_supply_i && startup_i |=> &ch_red_o && !ch_orange_o; endproperty
   a_cs: assert property (p_cs) else $error("start-up not red");
   property p_ce; mod_supply_i && ch_err_i[0] |=> ch_red_o[0] && !ch_orange_o[0]; endproperty
   a_ce: assert property (p_ce) else $error("channel error not red");
   property p_nd; $fell(mod_supply_i) |=> !ch_red_o && !ch_orange_o; endproperty
   a_nd: assert property (p_nd) else $error("channel lit unpowered");
   c_ss: cover property ($rose(ss));
   c_or: cover property (|ch_orange_o);
   c_in: cover property (inop_diag_o);
endmodule
bind smled_encoder smled_encoder_chk #(.NCH(NCH)) u_chk (.*);

// file: smled_encoder_tb.sv
`timescale 1ns/1ps
`include "smled_defines.vh"
module smled_encoder_tb;
   reg         clk_i, arst_n_i, mod_supply_i, io_supply_i, startup_i, avs_read_i, avs_write_i;
   reg         link_ok_i, cpu_ok_i, safe_comm_ok_i, fw_pilot_i, fw_inoperable_i, safety_active_i;
   reg  [2:0]  mod_state_i;
   reg  [1:0]  ch_err_i, ch_nonsafe_i, ch_set_i;
   reg  [3:0]  avs_address_i;
   reg  [31:0] avs_writedata_i, d;
   wire [31:0] avs_readdata_o;
   wire        avs_waitrequest_o, run_green_o, err_red_o, safety_state_indicator_o;
   wire        inop_diag_o, irq_o;
   wire [1:0]  ch_red_o, ch_orange_o, col0, col1;
   integer     bad_count, compares, i;
   always #50 clk_i = ~clk_i;
   // short slots keep a 12-slot frame at 48 cycles
   smled_encoder #(.SLOT_CYC(4), .NCH(2)) u_dut (.*);
   smled_panel u_p0 (.red_i(ch_red_o[0]), .orange_i(ch_orange_o[0]), .col_o(col0));
   smled_panel u_p1 (.red_i(ch_red_o[1]), .orange_i(ch_orange_o[1]), .col_o(col1));
   task chk(input [31:0] s, input [31:0] e);
      begin
         compares = compares + 1;
         if (s !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: saw %h not %h", $time, s, e);
         end
      end
   endtask
   task complete_run;
      begin
         $display("%0d compares, %0d mismatches", compares, bad_count);
         if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task tk;
      repeat (3) @(posedge clk_i);
   endtask
   task hs(input [5:0] v);
      {link_ok_i, cpu_ok_i, safe_comm_ok_i, fw_pilot_i, fw_inoperable_i, safety_active_i} <= v;
   endtask
   task bus(input w, input [3:0] a, input [31:0] v);
      integer k;
      begin
         @(posedge clk_i);
         {avs_write_i, avs_read_i, avs_address_i, avs_writedata_i} <= {w, !w, a, v};
         k = 0;
         do begin
            @(posedge clk_i);
            k = k + 1;
         end while (avs_waitrequest_o !== 1'b0 && k < 9);
         if (avs_waitrequest_o !== 1'b0) begin
            bad_count = bad_count + 1;
            complete_run;
         end
         d = avs_readdata_o;
         {avs_write_i, avs_read_i} <= 2'h0;
      end
   endtask
   // a whole frame is counted, so the flash phase does not matter
   task fr(input [2:0] s, input integer r, input integer e, input integer f);
      integer n, cr, ce, cf;
      begin
         mod_state_i <= s;
         {cr, ce, cf} = '0;
         tk;
         for (n = 0; n < 48; n = n + 1) begin
            @(posedge clk_i);
            cr = cr + run_green_o;
            ce = ce + err_red_o;
            cf = cf + safety_state_indicator_o;
         end
         if (r >= 0) chk(cr, r);
         if (e >= 0) chk(ce, e);
         if (f >= 0) chk(cf, f);
      end
   endtask
   initial begin
      {clk_i, arst_n_i, avs_read_i, avs_write_i, mod_state_i, ch_err_i, ch_nonsafe_i} = '0;
      {ch_set_i, avs_address_i, avs_writedata_i, fw_pilot_i, fw_inoperable_i} = '0;
      {mod_supply_i, io_supply_i, startup_i, link_ok_i, cpu_ok_i, safe_comm_ok_i} = 6'h3f;
      {safety_active_i, bad_count, compares} = '0;
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      startup_i <= 1'b0;
      bus(1'b1, 4'hc, 32'h7);
      fr(`SMLED_ST_RESET, 4, 0, -1);
      fr(`SMLED_ST_BOOT, -1, 24, 48);
      fr(`SMLED_ST_FWUPD, 8, 12, -1);
      fr(`SMLED_ST_PREOP, 24, 0, 48);
      fr(`SMLED_ST_RUN, 48, 0, 0);
      fr(`SMLED_ST_ERROR, -1, 48, -1);
      fr(3'h7, 0, 48, 0);
      fr(`SMLED_ST_BADCFG, 4, 48, -1);
      $display("flash test done");
      mod_state_i <= `SMLED_ST_RESET;
      for (i = 0; i < 6; i = i + 1) begin
         hs(6'h38 ^ (6'h20 >> i));
         tk;
         chk(safety_state_indicator_o, 1'b1);
      end
      chk(inop_diag_o, 1'b1);
      chk(irq_o, 1'b1);
      bus(1'b0, 4'h8, 32'h0);
      chk(d, 32'h1);
      bus(1'b1, 4'h8, 32'h1);
      tk;
      chk(irq_o, 1'b0);
      io_supply_i <= 1'b0;
      tk;
      chk(safety_state_indicator_o, 1'b0);
      io_supply_i <= 1'b1;
      mod_state_i <= `SMLED_ST_RUN;
      tk;
      chk(safety_state_indicator_o, 1'b0);
      $display("safety lamp test done");
      hs(6'h38);
      startup_i <= 1'b1;
      ch_set_i <= 2'h3;
      tk;
      chk({col1, col0}, 4'ha);
      startup_i <= 1'b0;
      ch_err_i <= 2'h1;
      tk;
      chk({col1, col0}, 4'h6);
      bus(1'b1, 4'hc, 32'h0);
      tk;
      chk(irq_o, 1'b0);
      bus(1'b0, 4'h8, 32'h0);
      chk(d, 32'h2);
      ch_err_i <= 2'h0;
      ch_nonsafe_i <= 2'h2;
      tk;
      chk({col1, col0}, 4'h9);
      bus(1'b0, 4'h4, 32'h0);
      chk(d, 32'h64);
      bus(1'b0, 4'h1, 32'h0);
      chk(d, 32'h0);
      mod_supply_i <= 1'b0;
      tk;
      chk({run_green_o, ch_red_o, ch_orange_o}, 5'h0);
      mod_state_i <= `SMLED_ST_RESET;
      bus(1'b1, 4'h0, 32'h1);
      tk;
      chk({run_green_o, err_red_o, ch_red_o, safety_state_indicator_o}, 5'h1f);
      bus(1'b0, 4'h0, 32'h0);
      chk(d, 32'h1);
      $display("channel test done");
      complete_run;
   end
endmodule
